// ---- logic/atp_pkg.sv ----
// constants and carrier types for the output test pattern register block
package atp_pkg;
   localparam int unsigned DATA_W = 12; // conversion word width
   localparam int unsigned WORD_W = 14; // output word incl. two compatibility bits
   localparam int unsigned EXTRA_W = 2; // compatibility bit count
   localparam int unsigned CHANNELS = 2; // converter channels
   localparam int unsigned FRAME_BITS = 16; // serial frame length
   localparam logic [4:0] CNT_ADDR_LAST = 5'h07; // index of the last header bit
   localparam logic [4:0] CNT_ADDR_DONE = 5'h08; // header complete
   localparam logic [4:0] CNT_LAST = 5'h0f; // index of the last data bit
   localparam logic [4:0] CNT_FRAME_DONE = 5'h10; // frame complete
   localparam logic [4:0] CNT_ZERO = 5'h00; // idle count
   localparam logic [4:0] CNT_ONE = 5'h01; // count step
   localparam int unsigned RW_BIT = 15; // frame bit: 1 = read
   localparam int unsigned HDR_RW_BIT = 7; // same bit once only the header is in
   localparam logic [6:0] ADDR_SOFT_RESET = 7'h00; // software reset register
   localparam logic [6:0] ADDR_PATTERN_HIGH = 7'h03; // test_pattern_high
   localparam logic [6:0] ADDR_PATTERN_LOW = 7'h04; // test_pattern_low
   localparam int unsigned SOFT_RESET_BIT = 7; // reset request bit
   localparam int unsigned ENABLE_BIT = 7; // pattern_enable in test_pattern_high
   localparam int unsigned DONT_CARE_BIT = 6; // unused bit in test_pattern_high
   localparam logic [7:0] HIGH_KEEP_MASK = 8'hbf; // drops the unused bit on write
   localparam logic [7:0] REG_RESET_VALUE = 8'h00; // all mode bits clear
   localparam logic [7:0] RD_RELEASE = 8'hff; // all ones leaves the open drain released
   localparam logic [1:0] EXTRA_ZERO = 2'h0; // extra bits in normal mode

   typedef logic [CHANNELS-1:0][DATA_W-1:0] atp_conv_t; // conversion data of both channels
   typedef logic [CHANNELS-1:0][WORD_W-1:0] atp_words_t; // output words of both channels

   // serial port and register state of the top module
   typedef struct packed {
      logic sck_prev; // serial clock one cycle ago
      logic [4:0] bit_cnt; // bits taken in this frame
      logic [15:0] shift; // incoming frame
      logic [7:0] rd_shift; // outgoing read data
      logic [7:0] high; // test_pattern_high
      logic [7:0] low; // test_pattern_low
      logic sdo_oe_n; // open-drain enable, low pulls the line down
      logic sdo_val; // value driven when enabled
   } atp_spi_state_t;

   // state of the output substitution stage
   typedef struct packed {
      atp_words_t word; // registered output words
      logic valid; // word strobe
   } atp_out_state_t;
endpackage : atp_pkg

// ---- logic/atp_pattern_mux.sv ----
// output stage that swaps conversion data for the stored test pattern
`timescale 1ns/1ps
module atp_pattern_mux (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic pattern_enable,
   input wire logic [atp_pkg::WORD_W-1:0] pattern_word,
   input wire logic sample_valid,
   input wire atp_pkg::atp_conv_t conv_data,
   output atp_pkg::atp_words_t out_word,
   output logic out_valid
);
   atp_pkg::atp_out_state_t st_r; // registered state
   atp_pkg::atp_out_state_t st_nxt; // next state

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // per sample: the same pattern on both channels, else data with zero extras
   always_comb begin
      st_nxt = st_r;
      st_nxt.valid = sample_valid;
      if (sample_valid) begin
         for (int i = 0; i < atp_pkg::CHANNELS; i++) begin
            if (pattern_enable) begin
               st_nxt.word[i] = pattern_word;
            end else begin
               st_nxt.word[i] = {conv_data[i], atp_pkg::EXTRA_ZERO};
            end
         end
      end
   end

   // state register
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign out_word = st_r.word;
   assign out_valid = st_r.valid;

   pattern_out_a: assert property (sample_valid && pattern_enable |=>
      out_valid && out_word[0] == $past(pattern_word) && out_word[1] == out_word[0])
      else $error("pattern not presented on both channels");
   normal_out_a: assert property (sample_valid && !pattern_enable |=>
      out_word[1] == {$past(conv_data[1]), atp_pkg::EXTRA_ZERO})
      else $error("conversion data not passed in normal mode");
endmodule : atp_pattern_mux

// ---- logic/atp_regs.sv ----
// serial-programmed test pattern registers with output substitution
//
// Behaviour
// - test_pattern_high bit 7 enables test pattern
// - test_pattern_high bit 6 is ignored
// - high bits 5-0 give pattern bits 11-6
// - low bits 7-2 give pattern bits 5-0
// - low bits 1-0 give two extra bits
// - software reset clears every pattern bit
//
// serial frame, msb first while chip_select_n is low:
//    bit 15     read request when set, write when clear
//    bits 14-8  register address
//    bits 7-0   data, written by the host or read back by the block
// a bit is taken on the core_clk edge that first sees serial_clk high,
// so serial_clk has to stay at each level for at least two core_clk cycles
// read data leaves on the falling edges after the eighth bit; a one leaves
// the open-drain line released and a zero pulls it down
// a one written to bit 7 of address 00h is the software reset; the bit is
// not stored and reads back as zero
// the pattern word handed to the mux is {high[5:0], low[7:0]}, fourteen bits
//
// limitations: the serial pins are taken as synchronous to core_clk, so a
// host on another clock needs its own synchroniser in front of this block;
// a frame cut short by chip_select_n is dropped without any write, and
// bits past the sixteenth are ignored until the next select
// the registers are reached only through this serial port; there is no
// parallel load in this block
`timescale 1ns/1ps
module atp_regs (
   input wire logic core_clk,
   input wire logic nrst,
   // serial configuration port
   input wire logic chip_select_n, // frame strobe, active low
   input wire logic serial_clk, // sampled as a plain input
   input wire logic serial_in_line,
   output logic serial_out_line_o,
   output logic serial_out_line_oe_n,
   // register fields for the output serializer
   output logic pattern_enable,
   output logic [5:0] pattern_upper_bits,
   output logic [5:0] pattern_lower_bits,
   output logic [1:0] pattern_extra_bits,
   // conversion data in, substituted output words out
   input wire logic sample_valid,
   input wire atp_pkg::atp_conv_t conv_data,
   output atp_pkg::atp_words_t out_word,
   output logic out_valid
);
   atp_pkg::atp_spi_state_t st_r; // registered state
   atp_pkg::atp_spi_state_t st_nxt; // next state
   logic sck_rise; // serial clock rising edge seen
   logic sck_fall; // serial clock falling edge seen
   logic [15:0] frame_in; // frame with the bit of this edge included
   logic wr_done; // last bit of a write frame taken now
   logic hdr_done; // eighth bit of a frame taken now

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);

   // register read decode, unmapped and write-only addresses read zero
   function automatic logic [7:0] reg_read(input logic [6:0] addr, input logic [7:0] high, input logic [7:0] low);
      logic [7:0] data;
      data = atp_pkg::REG_RESET_VALUE;
      // address 00h reads zero because the reset bit clears itself
      if (addr == atp_pkg::ADDR_PATTERN_HIGH) begin
         data = high;
      end else if (addr == atp_pkg::ADDR_PATTERN_LOW) begin
         data = low;
      end
      return data;
   endfunction : reg_read

   // edges of the serial clock, which is slow against core_clk
   // a level held for less than two core_clk cycles can lose an edge
   assign sck_rise = serial_clk && !st_r.sck_prev;
   assign sck_fall = !serial_clk && st_r.sck_prev;
   assign frame_in = {st_r.shift[14:0], serial_in_line};
   assign wr_done = !chip_select_n && sck_rise && st_r.bit_cnt == atp_pkg::CNT_LAST && !frame_in[atp_pkg::RW_BIT];
   assign hdr_done = !chip_select_n && sck_rise && st_r.bit_cnt == atp_pkg::CNT_ADDR_LAST;

   // serial frame engine and register writes
   always_comb begin
      st_nxt = st_r;
      // remember the serial clock for edge detection
      st_nxt.sck_prev = serial_clk;
      st_nxt.sdo_val = 1'b0; // open drain only ever pulls low
      if (chip_select_n) begin
         // deselect aborts a partial frame, nothing is written
         st_nxt.bit_cnt = atp_pkg::CNT_ZERO;
         // released at once so a cut read frame cannot hold the line low
         st_nxt.sdo_oe_n = 1'b1;
      end else begin
         // count only up to a full frame, later bits are ignored
         if (sck_rise && st_r.bit_cnt < atp_pkg::CNT_FRAME_DONE) begin
            // the new bit enters at the bottom, the first one ends up at bit 15
            st_nxt.shift = frame_in;
            // five bits so the count can reach sixteen
            st_nxt.bit_cnt = st_r.bit_cnt + atp_pkg::CNT_ONE;
            if (st_r.bit_cnt == atp_pkg::CNT_ADDR_LAST) begin
               // header complete: a read fetches data, a write keeps the line released
               if (frame_in[atp_pkg::HDR_RW_BIT]) begin
                  st_nxt.rd_shift = reg_read(frame_in[6:0], st_r.high, st_r.low);
               end else begin
                  st_nxt.rd_shift = atp_pkg::RD_RELEASE;
               end
            end
            // a write lands once the sixteenth bit is in; read frames never get here
            if (wr_done) begin
               case (frame_in[14:8])
                  atp_pkg::ADDR_SOFT_RESET: begin
                     // the reset bit itself is not stored, so it reads back as zero
                     if (frame_in[atp_pkg::SOFT_RESET_BIT]) begin
                        st_nxt.high = atp_pkg::REG_RESET_VALUE;
                        st_nxt.low = atp_pkg::REG_RESET_VALUE;
                     end
                  end
                  atp_pkg::ADDR_PATTERN_HIGH: begin
                     // bit 6 is masked off so it never reaches the register
                     st_nxt.high = frame_in[7:0] & atp_pkg::HIGH_KEEP_MASK;
                  end
                  atp_pkg::ADDR_PATTERN_LOW: begin
                     // all eight bits are pattern bits, the lowest two are the extra ones
                     st_nxt.low = frame_in[7:0];
                  end
                  default: begin
                     // other mode registers live outside this block
                     st_nxt.low = st_r.low;
                  end
               endcase
            end
         end
         // read data leaves on falling edges so it is settled for the next rising one
         if (sck_fall && st_r.bit_cnt >= atp_pkg::CNT_ADDR_DONE && st_r.bit_cnt < atp_pkg::CNT_FRAME_DONE) begin
            // a zero bit enables the pull-down, a one releases the line
            st_nxt.sdo_oe_n = st_r.rd_shift[7];
            // ones shifted in are never driven; the line keeps the last data bit until deselect
            st_nxt.rd_shift = {st_r.rd_shift[6:0], 1'b1};
         end
      end
   end

   // state register, nrst and the software reset both leave the high and low registers zero
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         st_r <= '0;
         // the open-drain line starts released, every other bit starts at zero
         st_r.sdo_oe_n <= 1'b1;
      end else begin
         // one register stage for all state keeps every output on a flip-flop
         st_r <= st_nxt;
      end
   end

   // field outputs come straight from the register bits
   assign pattern_enable = st_r.high[atp_pkg::ENABLE_BIT];
   assign pattern_upper_bits = st_r.high[5:0];
   assign pattern_lower_bits = st_r.low[7:2];
   assign pattern_extra_bits = st_r.low[1:0];

   // open-drain pin of the serial port
   assign serial_out_line_o = st_r.sdo_val;
   assign serial_out_line_oe_n = st_r.sdo_oe_n;

   // substitution stage shared by both channels
   // its words are registered, so a new enable shows from the next sample on
   atp_pattern_mux u_mux (
      .core_clk(core_clk),
      .nrst(nrst),
      .pattern_enable(st_r.high[atp_pkg::ENABLE_BIT]),
      .pattern_word({st_r.high[5:0], st_r.low}),
      .sample_valid(sample_valid),
      .conv_data(conv_data),
      .out_word(out_word),
      .out_valid(out_valid)
   );

   // a write to the high register moves bit 7 into the enable
   enable_write_a: assert property (wr_done && frame_in[14:8] == atp_pkg::ADDR_PATTERN_HIGH |=>
      pattern_enable == $past(frame_in[7])) else $error("enable bit not taken from bit 7");
   // the unused bit never holds a one
   dont_care_a: assert property (st_r.high[atp_pkg::DONT_CARE_BIT] == 1'b0)
      else $error("unused bit was stored");
   // bits 5-0 of the high register become pattern bits 11-6
   upper_bits_a: assert property (wr_done && frame_in[14:8] == atp_pkg::ADDR_PATTERN_HIGH |=>
      pattern_upper_bits == $past(frame_in[5:0])) else $error("upper pattern bits wrong");
   // bits 7-2 of the low register become pattern bits 5-0
   lower_bits_a: assert property (wr_done && frame_in[14:8] == atp_pkg::ADDR_PATTERN_LOW |=>
      pattern_lower_bits == $past(frame_in[7:2])) else $error("lower pattern bits wrong");
   // bits 1-0 of the low register become the extra bits
   extra_bits_a: assert property (wr_done && frame_in[14:8] == atp_pkg::ADDR_PATTERN_LOW |=>
      pattern_extra_bits == $past(frame_in[1:0])) else $error("extra pattern bits wrong");
   // a software reset clears both registers
   soft_reset_a: assert property (wr_done && frame_in[14:8] == atp_pkg::ADDR_SOFT_RESET && frame_in[7] |=>
      !pattern_enable && pattern_upper_bits == 6'h0 && st_r.low == 8'h00) else $error("software reset left bits set");
   // nothing is written while the port is deselected
   hold_regs_a: assert property (chip_select_n |=> $stable(st_r.high) && $stable(st_r.low))
      else $error("register changed while deselected");

   // read-back of the high register loads what is stored, bit 6 as zero
   read_high_a: assert property (hdr_done && frame_in[atp_pkg::HDR_RW_BIT] &&
      frame_in[6:0] == atp_pkg::ADDR_PATTERN_HIGH |=> st_r.rd_shift == $past(st_r.high))
      else $error("high register read back wrong");
   // read-back of the low register loads all eight stored bits
   read_low_a: assert property (hdr_done && frame_in[atp_pkg::HDR_RW_BIT] &&
      frame_in[6:0] == atp_pkg::ADDR_PATTERN_LOW |=> st_r.rd_shift == $past(st_r.low))
      else $error("low register read back wrong");
   // a read frame never changes a register
   read_only_a: assert property (!chip_select_n && sck_rise && st_r.bit_cnt == atp_pkg::CNT_LAST &&
      frame_in[atp_pkg::RW_BIT] |=> $stable(st_r.high) && $stable(st_r.low))
      else $error("read frame changed a register");
   // writes to the other mode registers leave the pattern alone
   other_addr_a: assert property (wr_done && frame_in[14:8] != atp_pkg::ADDR_PATTERN_HIGH &&
      frame_in[14:8] != atp_pkg::ADDR_PATTERN_LOW && frame_in[14:8] != atp_pkg::ADDR_SOFT_RESET |=>
      $stable(st_r.high) && $stable(st_r.low)) else $error("write to another address changed the pattern");
   // deselect drops a partial frame and restarts the count
   abort_frame_a: assert property (chip_select_n |=> st_r.bit_cnt == atp_pkg::CNT_ZERO)
      else $error("bit count not cleared on deselect");
   // output word 1 carries the stored fields from msb to lsb
   pattern_word_a: assert property (sample_valid && pattern_enable |=>
      out_word[1] == {$past(pattern_upper_bits), $past(pattern_lower_bits), $past(pattern_extra_bits)})
      else $error("pattern fields not in output order");
endmodule : atp_regs

// ---- tb/atp_host.sv ----
// serial configuration host model for the test pattern register port
`timescale 1ns/1ps
module atp_host (
   input wire logic core_clk,
   output logic chip_select_n,
   output logic serial_clk,
   output logic serial_in_line,
   input wire logic serial_out_line_o,
   input wire logic serial_out_line_oe_n
);
   logic line_lvl; // open-drain line as the host sees it
   // external pull-up: released line reads high
   assign line_lvl = serial_out_line_oe_n ? 1'b1 : serial_out_line_o;
   // idle: deselected, serial clock parked low between frames
   initial begin
      chip_select_n = 1'b1;
      serial_clk = 1'b0;
      serial_in_line = 1'b0;
   end
   // one frame msb first; fewer than 16 bits aborts it; three cycles per phase keeps the two-cycle minimum
   task automatic xfer(input logic [15:0] frm, input int nbits, output logic [7:0] rd);
      rd = 8'h00;
      @(posedge core_clk);
      #1 chip_select_n = 1'b0;
      for (int i = 15; i > 15 - nbits; i--) begin
         serial_in_line = frm[i];
         repeat (2) @(posedge core_clk);
         // read bits land after the fall, sample late in the low phase
         #1 if (i < 8) rd[i] = line_lvl;
         @(posedge core_clk);
         #1 serial_clk = 1'b1;
         repeat (3) @(posedge core_clk);
         #1 serial_clk = 1'b0;
      end
      repeat (3) @(posedge core_clk);
      #1 chip_select_n = 1'b1;
      // released data line must not keep looking valid
      serial_in_line = ~serial_in_line;
      repeat (4) @(posedge core_clk);
   endtask : xfer
endmodule : atp_host

// ---- tb/testbench.sv ----
// self-checking bench for the test pattern registers and output swap
`timescale 1ns/1ps
module testbench;
   typedef struct packed {
      logic [6:0] addr; // register address
      logic [7:0] wdata; // value written
      logic [7:0] rdata; // value read back
      logic [13:0] pat; // {enable, upper, lower, extra} minus enable: {upper, lower, extra}
      logic en; // expected enable
   } atp_row_t;
   logic core_clk, nrst, chip_select_n, serial_clk, serial_in_line, sdo_o, sdo_oe_n;
   logic pattern_enable, sample_valid, out_valid;
   logic [5:0] upper, lower;
   logic [1:0] extra;
   logic [13:0] pat_now; // pattern outputs gathered into one word
   logic [7:0] rd; // read-back byte
   atp_pkg::atp_conv_t conv_data;
   atp_pkg::atp_words_t out_word;
   int mismatches = 0;
   int cmp_count = 0;
   // bit 6 of 03h dropped, unmapped 05h reads zero and changes nothing
   atp_row_t rows [5] = '{
      '{7'h03, 8'hc5, 8'h85, 14'h0500, 1'b1}, '{7'h04, 8'ha7, 8'ha7, 14'h05a7, 1'b1},
      '{7'h03, 8'h7f, 8'h3f, 14'h3fa7, 1'b0}, '{7'h05, 8'hff, 8'h00, 14'h3fa7, 1'b0},
      '{7'h03, 8'hba, 8'hba, 14'h3aa7, 1'b1}};
   assign pat_now = {upper, lower, extra};
   atp_regs atp_regs_i (.core_clk(core_clk), .nrst(nrst), .chip_select_n(chip_select_n),
      .serial_clk(serial_clk), .serial_in_line(serial_in_line), .serial_out_line_o(sdo_o),
      .serial_out_line_oe_n(sdo_oe_n), .pattern_enable(pattern_enable), .pattern_upper_bits(upper),
      .pattern_lower_bits(lower), .pattern_extra_bits(extra), .sample_valid(sample_valid),
      .conv_data(conv_data), .out_word(out_word), .out_valid(out_valid));
   atp_host atp_host_i (.core_clk(core_clk), .chip_select_n(chip_select_n), .serial_clk(serial_clk),
      .serial_in_line(serial_in_line), .serial_out_line_o(sdo_o), .serial_out_line_oe_n(sdo_oe_n));
   // 200 MHz core clock
   initial core_clk = 1'b0;
   always #2.5 core_clk = ~core_clk;
   task automatic chk_pat(input logic [13:0] got, input logic [13:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_pat
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk_byte
   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : give_verdict
   // watchdog: the whole run needs about 8 us
   initial begin
      #200000;
      mismatches++;
      give_verdict();
   end
   // main sequence
   initial begin
      nrst = 1'b0;
      sample_valid = 1'b0;
      conv_data = 24'h00_0000;
      repeat (4) @(posedge core_clk);
      #1 nrst = 1'b1;
      chk_pat(pat_now, 14'h0000);
      chk_byte({7'h00, pattern_enable}, 8'h00);
      atp_host_i.xfer(16'h0080, 16, rd);
      $display("reset test done");
      foreach (rows[k]) begin
         atp_host_i.xfer({1'b0, rows[k].addr, rows[k].wdata}, 16, rd);
         chk_byte({7'h00, pattern_enable}, {7'h00, rows[k].en});
         chk_pat(pat_now, rows[k].pat);
         atp_host_i.xfer({1'b1, rows[k].addr, 8'h00}, 16, rd);
         chk_byte(rd, rows[k].rdata);
         $display("row %0d done", k);
      end
      // back-to-back samples with the pattern on: both channels carry the stored word
      #1 sample_valid = 1'b1;
      conv_data = 24'h12_3456;
      @(posedge core_clk);
      #1 conv_data = 24'hab_cdef;
      chk_byte({7'h00, out_valid}, 8'h01);
      chk_pat(out_word[0], 14'h3aa7);
      chk_pat(out_word[1], 14'h3aa7);
      @(posedge core_clk);
      #1 sample_valid = 1'b0;
      chk_pat(out_word[1], 14'h3aa7);
      @(posedge core_clk);
      #1 chk_byte({7'h00, out_valid}, 8'h00);
      atp_host_i.xfer(16'h033a, 16, rd);
      #1 sample_valid = 1'b1;
      conv_data = 24'h12_3456;
      @(posedge core_clk);
      #1 sample_valid = 1'b0;
      chk_pat(out_word[0], 14'h1158);
      chk_pat(out_word[1], 14'h048c);
      $display("data path test done");
      // aborted frame leaves the low register alone
      atp_host_i.xfer(16'h0400, 10, rd);
      chk_pat(pat_now, 14'h3aa7);
      // software reset in mid-run clears everything, the enable included
      atp_host_i.xfer(16'h03ff, 16, rd);
      chk_byte({7'h00, pattern_enable}, 8'h01);
      atp_host_i.xfer(16'h0080, 16, rd);
      chk_pat(pat_now, 14'h0000);
      chk_byte({7'h00, pattern_enable}, 8'h00);
      atp_host_i.xfer(16'h8300, 16, rd);
      chk_byte(rd, 8'h00);
      $display("abort and soft reset test done");
      give_verdict();
   end
endmodule : testbench
